//--- low_power_mode_sequencer_bench.sv
// Purpose: directed bench for lpms_seq
// Assumes: 50 MHz mclk
// Notes: wake latencies compared between runs
`timescale 1ns/1ns
module low_power_mode_sequencer_bench;
  logic mclk = 1'h0;
  logic resetn = 1'h0;
  lpms_pkg::lpms_cfg_s cfg = '0;
  lpms_pkg::lpms_src_s src = '0;
  logic [15:0] main_reg_ready_delay = 16'h000A;
  logic wait_irq_instr = 1'h0;
  logic wait_event_instr = 1'h0;
  logic isr_return_last = 1'h0;
  logic hf_osc_ready, cpu_clk_en_q, core_clk_en_q, hf_osc_en_q;
  logic ext_osc_force_off_q, lowpwr_reg_on_q, sysclk_sel_internal_q;
  logic nvm_ready_q, wake_pulse_q, stop_ignored_q;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int lat;
  int base;
  int ign = 0;
  // count cancelled-stop pulses for the refuse checks
  always @(posedge mclk)
    if (stop_ignored_q === 1'h1)
      ign++;
  lpms_seq lpms_seq_i (.*);
  lpms_osc_model lpms_osc_model_i (.mclk(mclk), .en(hf_osc_en_q),
    .ready(hf_osc_ready));
  always #10 mclk = ~mclk;
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'h1)
    begin
      errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // one-cycle entry pulse: 0 wait irq, 1 wait event, 2 handler return
  task automatic enter(input int k);
    @(posedge mclk);
    wait_irq_instr <= k == 0;
    wait_event_instr <= k == 1;
    isr_return_last <= k == 2;
    @(posedge mclk);
    {wait_irq_instr, wait_event_instr, isr_return_last} <= 3'h0;
    repeat (2) @(posedge mclk);
  endtask
  // hold a wake source until the wake pulse, counting cycles
  task automatic wake(input lpms_pkg::lpms_src_s w);
    src <= w;
    for (lat = 0; lat < 3000 && wake_pulse_q !== 1'h1; lat++)
      @(posedge mclk);
    src <= '0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic t_sleep(input int k, input lpms_pkg::lpms_src_s w);
    cfg.return_sleep_select <= k == 2;
    cfg.pending_as_event <= w.irq_pending;
    enter(k);
    chk(!cpu_clk_en_q && core_clk_en_q, "sleep");
    wake(w);
    chk(lat == 2, "sleep wake");
    $display("sleep test %0d done", k);
  endtask
  task automatic t_refuse(input lpms_pkg::lpms_src_s w);
    int n;
    n = ign;
    src <= w;
    cfg.deep_sleep_select <= 1'h1;
    enter(0);
    chk(cpu_clk_en_q === 1'h1, "refused stop");
    chk((ign - n == 1) == w.any_pending, "ignore pulse");
    src <= '0;
    cfg.deep_sleep_select <= 1'h0;
    $display("refuse test done");
  endtask
  task automatic t_stop(input logic [1:0] r, n, input int k);
    cfg.low_power_regulator_select <= r;
    cfg.nvm_wake_wait <= n;
    cfg.pending_as_event <= 1'h1;
    cfg.deep_sleep_select <= 1'h1;
    enter(k);
    chk(!hf_osc_en_q && ext_osc_force_off_q && !core_clk_en_q, "stop");
    chk(nvm_ready_q === 1'h0, "flash idle in stop");
    chk(lowpwr_reg_on_q === (r == 2'h1), "regulator");
    wake(k ? 7'h30 : 7'h08);
    chk(lat < 3000 && sysclk_sel_internal_q === 1'h1, "stop wake");
    cfg.deep_sleep_select <= 1'h0;
    $display("stop test done");
  endtask
  task automatic end_sim;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_sim;
    end
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    resetn <= 1'h1;
    t_sleep(0, 7'h40);
    t_sleep(1, 7'h10);
    t_sleep(1, 7'h20);
    t_sleep(2, 7'h40);
    t_refuse(7'h02);
    t_refuse(7'h01);
    t_refuse(7'h04);
    t_stop(2'h0, 2'h3, 0);
    t_stop(2'h0, 2'h3, 1);
    base = lat;
    t_stop(2'h0, 2'h0, 1);
    chk(lat - base == lpms_pkg::NVM_WAIT0_CYC, "wait 00");
    t_stop(2'h0, 2'h1, 1);
    chk(lat - base == lpms_pkg::NVM_WAIT1_CYC, "wait 01");
    t_stop(2'h0, 2'h2, 1);
    chk(lat - base == lpms_pkg::NVM_WAIT2_CYC, "wait 10");
    t_stop(2'h1, 2'h3, 1);
    chk(lat - base == main_reg_ready_delay + 1, "reg wait");
    base = lat;
    cfg.hf_osc_wake_timing <= 1'h1;
    t_stop(2'h1, 2'h3, 1);
    chk(lat < base, "early osc");
    end_sim;
  end
endmodule

//--- lpms_osc_model.sv
// Purpose: fast oscillator seen by the sequencer
// Assumes: start-up count in mclk cycles
// Notes: ready drops at once when disabled
`timescale 1ns/1ns
module lpms_osc_model #(
  parameter int unsigned START_CYC = 6
) (
  // clock and enable
  input wire logic mclk,
  input wire logic en,
  // stable flag
  output logic ready = 1'h0
);
  int unsigned cnt = 0;
  // ready after a run of enabled cycles
  always @(posedge mclk)
  begin
    cnt <= en ? cnt + 1 : 0;
    ready <= en && cnt >= START_CYC;
  end
endmodule

//--- lpms_pkg.sv
// Purpose: constants and carriers for the low-power mode sequencer
// Assumes: 50 MHz mclk, one clock domain, control bits arrive as ports
// Notes: flash wait times are in ns and turned into cycle counts here; the regulator delay arrives in cycles
// How it works
// - with both select bits clear, a wait instruction enters sleep at once.
// - return_sleep_select alone enters sleep on return from the last handler.
// - pins keep their run-mode state during sleep and stop.
// - wait_irq sleep wakes on any interrupt accepted by the controller.
// - wait_event sleep wakes on an event; pending irq counts if pending_as_event.
// - event-mode line wakes wait_event sleep without setting pending bits.
// - sleep wake-up resumes at once with no extra latency.
// - stop turns off both fast oscillators and keeps SRAM and registers.
// - stop keeps wake logic, low-speed parts as configured, gates other clocks.
// - low-power regulator powers the core in stop when selected.
// - stop entry is dropped, not held, while a flash program or erase is busy.
// - stop entry is dropped, not held, while a peripheral-bus access is in progress.
// - any pending bit or alarm at a stop request cancels it.
// - waking from stop selects the internal fast oscillator as system clock.
// - an extra regulator settle delay follows stop on the low-power regulator.
// - stop wake runs regulator, then oscillator, then flash wait in order.
// - wait_irq stop wakes on an interrupt-mode line enabled in the controller.
// - wait_event stop wakes on event-mode line or pending irq with pending_as_event.
// - flash wait code 00 is 5us, 01 is 2us, 10 is 3us, 11 none.
// - regulator code 00 is main regulator, 01 is low-power, others reserved.
// - oscillator timing 0 waits for regulator, 1 starts both together.
package lpms_pkg;
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned NVM_WAIT0_NS = 5000;
  localparam int unsigned NVM_WAIT1_NS = 2000;
  localparam int unsigned NVM_WAIT2_NS = 3000;
  localparam int unsigned NVM_WAIT0_CYC = (NVM_WAIT0_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned NVM_WAIT1_CYC = (NVM_WAIT1_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned NVM_WAIT2_CYC = (NVM_WAIT2_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] REG_MAIN = 2'h0;
  localparam logic [1:0] REG_LOWPWR = 2'h1;
  localparam logic [1:0] NVM_WAIT_RST = 2'h0;
  localparam int unsigned CNT_W = 16;

  typedef enum logic [2:0] {
    ST_RUN, ST_SLEEP, ST_STOP, ST_REG_WAIT, ST_OSC_WAIT, ST_NVM_WAIT
  } lpms_state_e;

  // core-side control bits
  typedef struct packed {
    logic return_sleep_select;
    logic deep_sleep_select;
    logic pending_as_event;
    logic [1:0] low_power_regulator_select;
    logic [1:0] nvm_wake_wait;
    logic hf_osc_wake_timing;
  } lpms_cfg_s;

  // wake and blocking sources
  typedef struct packed {
    logic irq_accepted;
    logic irq_pending;
    logic event_line;
    logic ext_event_ctrl_irq_line;
    logic any_pending;
    logic flash_busy_flag;
    logic pbus_busy;
  } lpms_src_s;
endpackage

//--- lpms_seq.sv
// Purpose: low-power mode sequencer for sleep and stop entry and wake
// Assumes: inputs synchronous to mclk, oscillator ready arrives as a level
// Notes: pins are never touched here, so they hold run-mode state
`timescale 1ns/1ns
module lpms_seq #(
  parameter int unsigned MAIN_REG_READY_DEFAULT = 100
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // configuration
  input wire lpms_pkg::lpms_cfg_s cfg,
  input wire logic [15:0] main_reg_ready_delay,
  // core events
  input wire logic wait_irq_instr,
  input wire logic wait_event_instr,
  input wire logic isr_return_last,
  input wire lpms_pkg::lpms_src_s src,
  input wire logic hf_osc_ready,
  // outputs
  output logic cpu_clk_en_q,
  output logic core_clk_en_q,
  output logic hf_osc_en_q,
  output logic ext_osc_force_off_q,
  output logic lowpwr_reg_on_q,
  output logic sysclk_sel_internal_q,
  output logic nvm_ready_q,
  output logic wake_pulse_q,
  output logic stop_ignored_q
);
  lpms_pkg::lpms_state_e state_q;
  logic [lpms_pkg::CNT_W-1:0] cnt_q;
  logic by_event_q;
  logic used_lpr_q;
  logic entry_req;
  logic stop_ok;
  logic wake_sleep;
  logic wake_stop;
  logic [lpms_pkg::CNT_W-1:0] nvm_cyc;

  // a wait instruction, or handler return with return-sleep enabled
  assign entry_req = wait_irq_instr | wait_event_instr
    | (isr_return_last & cfg.return_sleep_select);
  // stop proceeds only with no pending bits and no busy flash or bus
  assign stop_ok = ~src.any_pending & ~src.flash_busy_flag
    & ~src.pbus_busy;
  // sleep wake sources by entry kind
  assign wake_sleep = by_event_q
    ? (src.event_line | (src.irq_pending & cfg.pending_as_event))
    : src.irq_accepted;
  // stop wake sources by entry kind
  assign wake_stop = by_event_q
    ? (src.event_line | (src.irq_pending & cfg.pending_as_event))
    : src.ext_event_ctrl_irq_line;

  // flash wake wait decode
  always_comb
  begin
    unique case (cfg.nvm_wake_wait)
      2'h0: nvm_cyc = lpms_pkg::CNT_W'(lpms_pkg::NVM_WAIT0_CYC);
      2'h1: nvm_cyc = lpms_pkg::CNT_W'(lpms_pkg::NVM_WAIT1_CYC);
      2'h2: nvm_cyc = lpms_pkg::CNT_W'(lpms_pkg::NVM_WAIT2_CYC);
      2'h3: nvm_cyc = '0;
    endcase
  end

  // mode sequencing
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state_q <= lpms_pkg::ST_RUN;
      cnt_q <= '0;
      by_event_q <= 1'b0;
      used_lpr_q <= 1'b0;
      stop_ignored_q <= 1'b0;
      wake_pulse_q <= 1'b0;
    end
    else
    begin
      stop_ignored_q <= 1'b0;
      wake_pulse_q <= 1'b0;
      unique case (state_q)
        lpms_pkg::ST_RUN:
        begin
          if (entry_req)
          begin
            by_event_q <= wait_event_instr;
            if (!cfg.deep_sleep_select)
              state_q <= lpms_pkg::ST_SLEEP;
            else if (stop_ok)
            begin
              state_q <= lpms_pkg::ST_STOP;
              used_lpr_q <= (cfg.low_power_regulator_select
                == lpms_pkg::REG_LOWPWR);
            end
            else if (src.any_pending)
              stop_ignored_q <= 1'b1;
          end
        end
        lpms_pkg::ST_SLEEP:
        begin
          if (wake_sleep)
          begin
            state_q <= lpms_pkg::ST_RUN;
            wake_pulse_q <= 1'b1;
          end
        end
        lpms_pkg::ST_STOP:
        begin
          if (wake_stop)
          begin
            if (used_lpr_q)
            begin
              state_q <= lpms_pkg::ST_REG_WAIT;
              cnt_q <= main_reg_ready_delay;
            end
            else
              state_q <= lpms_pkg::ST_OSC_WAIT;
          end
        end
        lpms_pkg::ST_REG_WAIT:
        begin
          if (cnt_q == '0)
            state_q <= lpms_pkg::ST_OSC_WAIT;
          else
            cnt_q <= cnt_q - 1'b1;
        end
        lpms_pkg::ST_OSC_WAIT:
        begin
          if (hf_osc_ready)
          begin
            state_q <= lpms_pkg::ST_NVM_WAIT;
            cnt_q <= nvm_cyc;
          end
        end
        lpms_pkg::ST_NVM_WAIT:
        begin
          if (cnt_q == '0)
          begin
            state_q <= lpms_pkg::ST_RUN;
            wake_pulse_q <= 1'b1;
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
        default: state_q <= lpms_pkg::ST_RUN;
      endcase
    end
  end

  // clock gating, oscillator and regulator controls
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      cpu_clk_en_q <= 1'b1;
      core_clk_en_q <= 1'b1;
      hf_osc_en_q <= 1'b1;
      ext_osc_force_off_q <= 1'b0;
      lowpwr_reg_on_q <= 1'b0;
      sysclk_sel_internal_q <= 1'b1;
      nvm_ready_q <= 1'b1;
    end
    else
    begin
      cpu_clk_en_q <= (state_q == lpms_pkg::ST_RUN);
      core_clk_en_q <= (state_q == lpms_pkg::ST_RUN)
        || (state_q == lpms_pkg::ST_SLEEP);
      lowpwr_reg_on_q <= used_lpr_q && (state_q == lpms_pkg::ST_STOP);
      nvm_ready_q <= (state_q == lpms_pkg::ST_RUN)
        || (state_q == lpms_pkg::ST_SLEEP);
      unique case (state_q)
        lpms_pkg::ST_STOP:
        begin
          // early start on the low-power regulator only when asked for
          hf_osc_en_q <= wake_stop
            && (!used_lpr_q || cfg.hf_osc_wake_timing);
          ext_osc_force_off_q <= 1'b1;
        end
        lpms_pkg::ST_REG_WAIT:
          // enable on the last settle cycle so the osc wait starts in step
          hf_osc_en_q <= cfg.hf_osc_wake_timing || (cnt_q == '0);
        lpms_pkg::ST_OSC_WAIT, lpms_pkg::ST_NVM_WAIT:
        begin
          hf_osc_en_q <= 1'b1;
          sysclk_sel_internal_q <= 1'b1;
        end
        default:
        begin
          hf_osc_en_q <= 1'b1;
          ext_osc_force_off_q <= 1'b0;
        end
      endcase
    end
  end
endmodule

//--- lpms_seq_asserts.sv
// Purpose: port checks for lpms_seq
// Assumes: one mclk domain
// Notes: bound into every lpms_seq
`timescale 1ns/1ns
module lpms_seq_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // inputs
  input wire lpms_pkg::lpms_cfg_s cfg,
  input wire lpms_pkg::lpms_src_s src,
  input wire logic wait_irq_instr,
  input wire logic wait_event_instr,
  input wire logic isr_return_last,
  // outputs
  input wire logic cpu_clk_en_q,
  input wire logic core_clk_en_q,
  input wire logic hf_osc_en_q,
  input wire logic ext_osc_force_off_q,
  input wire logic lowpwr_reg_on_q,
  input wire logic sysclk_sel_internal_q,
  input wire logic wake_pulse_q,
  input wire logic stop_ignored_q
);
  logic go;
  logic slp;
  logic ev_q;
  logic dq;
  assign go = (wait_irq_instr || wait_event_instr) && cpu_clk_en_q;
  assign slp = !cpu_clk_en_q && core_clk_en_q && !wake_pulse_q && !dq;
  // entry kind, and stop seen since the last wake
  always_ff @(posedge mclk)
  begin
    if (wait_irq_instr || wait_event_instr || isr_return_last)
      ev_q <= wait_event_instr;
    dq <= resetn && !wake_pulse_q && (dq || !core_clk_en_q);
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  sequence s_wake;
    ##1 wake_pulse_q ##1 cpu_clk_en_q;
  endsequence
  AST_SLEEP_NOW: assert property (
    go && cfg[7:6] == 2'h0 |-> ##2 slp) else $error("sleep entry");
  AST_ON_EXIT: assert property (
    isr_return_last && cpu_clk_en_q && cfg[7:6] == 2'h2 |-> ##2 slp)
    else $error("sleep on exit");
  AST_IRQ_WAKE: assert property (
    slp && !ev_q && src.irq_accepted |-> s_wake) else $error("irq wake");
  AST_EV_WAKE: assert property (
    slp && ev_q && (src.event_line || src.irq_pending && cfg[5])
    |-> s_wake) else $error("event wake");
  AST_STOP: assert property (
    go && cfg[6] && src[2:0] == 3'h0
    |-> ##2 !core_clk_en_q && !hf_osc_en_q && ext_osc_force_off_q)
    else $error("stop entry");
  AST_REG: assert property (
    $rose(ext_osc_force_off_q) |-> lowpwr_reg_on_q ==
    (cfg.low_power_regulator_select == lpms_pkg::REG_LOWPWR))
    else $error("regulator");
  AST_BUSY: assert property (
    go && cfg[6] && src[2:0] inside {3'h1, 3'h2}
    |-> ##1 cpu_clk_en_q [*3]) else $error("busy stop");
  AST_IGNORE: assert property (
    go && cfg[6] && src[2:0] == 3'h4
    |-> ##1 stop_ignored_q ##1 !stop_ignored_q && cpu_clk_en_q)
    else $error("pending stop");
  AST_CLK: assert property (
    wake_pulse_q |-> sysclk_sel_internal_q) else $error("clock source");
endmodule
bind lpms_seq lpms_seq_asserts lpms_seq_asserts_i (.*);
